/* File: logic/stm_ctrl.v */
// standard timer module control with axi4-lite register slave
// Overview of operation
// - pause bit high stops the counter advancing; low lets it count again
// - paused counter holds its value and continues from it after unpause
// - clock select: sys/4, sys, high/16, high/64, timebase, pin rise/fall
// - undefined clock select code gives no count ticks at all
// - on/off low holds counter; a rising on/off edge clears it to zero
// - compare mode: on/off rising edge sets pin to its initial level
// - period field compared with counter bits 9..7; 000 means 1024 clocks
// - clear select low: period match clears the counter
// - period field zero lets the counter run to overflow
// - mode field: compare output, capture, pwm/single pulse, plain timer
// - compare mode, match a: pin unchanged, low, high or toggled
// - pwm mode: hold inactive, hold active, pwm waveform, single pulse
// - capture mode: rising, falling, either edge, or capture disabled
// - match level equal to initial level leaves the pin unchanged
// - plain timer mode leaves the output pin undriven
// - polarity bit inverts the pin in compare and pwm modes only
// - swap bit, pwm mode only: 0 period field sets period, 1 compare a sets period
// - clear select high: match a clears counter, except pwm and capture
//
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
`include "stm_map.vh"
`default_nettype none

module stm_ctrl
(
   input wire CLK, // system clock, 50 MHz
   input wire ARST_N, // asynchronous reset, active low
   input wire EXT_CLK_PIN, // external count clock pin
   input wire TIMEBASE_CLK, // timebase clock from elsewhere
   input wire TP_IN, // timer pin input level
   output reg TP_OUT, // timer pin output level
   output reg TP_OE, // timer pin output enable
   input wire [7:0] AWADDR, // write address
   input wire AWVALID, // write address valid
   output reg AWREADY, // write address ready
   input wire [31:0] WDATA, // write data
   input wire [3:0] WSTRB, // write byte strobes
   input wire WVALID, // write data valid
   output reg WREADY, // write data ready
   output reg [1:0] BRESP, // write response
   output reg BVALID, // write response valid
   input wire BREADY, // write response ready
   input wire [7:0] ARADDR, // read address
   input wire ARVALID, // read address valid
   output reg ARREADY, // read address ready
   output reg [31:0] RDATA, // read data
   output reg [1:0] RRESP, // read response
   output reg RVALID, // read data valid
   input wire RREADY // read data ready
);

   reg [7:0] ctrl0;
   reg [7:0] ctrl1;
   reg [9:0] cmpa;
   reg [9:0] count;
   reg [9:0] capture;
   reg flag_a;
   reg flag_p;
   reg aw_got;
   reg w_got;
   reg [7:0] aw_addr;
   reg [31:0] w_data;
   reg w_lane0;
   reg [5:0] prediv;
   reg ext_s1, ext_s2, ext_s3;
   reg tb_s1, tb_s2, tb_s3;
   reg tp_s1, tp_s2, tp_s3;
   reg on_prev;
   reg out_state;
   reg pulse_active;
   reg [31:0] rd_word;
   reg rd_ok;
   reg wr_ok;
   reg sel_tick;
   reg clr_hit;
   reg next_tp_out;
   reg next_tp_oe;
   reg cap_edge;

   wire pause = ctrl0[`STM_PAUSE_BIT];
   wire [2:0] cksel = ctrl0[`STM_CKSEL_HI:`STM_CKSEL_LO];
   wire on = ctrl0[`STM_ON_BIT];
   wire [2:0] period = ctrl0[`STM_PERIOD_HI:`STM_PERIOD_LO];
   wire [1:0] mode = ctrl1[`STM_MODE_HI:`STM_MODE_LO];
   wire [1:0] ofn = ctrl1[`STM_OFN_HI:`STM_OFN_LO];
   wire init_lvl = ctrl1[`STM_INIT_BIT];
   wire pol = ctrl1[`STM_POL_BIT];
   wire swap = ctrl1[`STM_SWAP_BIT];
   wire clrsel = ctrl1[`STM_CLRSEL_BIT];

   wire on_rise = on & ~on_prev;
   wire do_write = aw_got & w_got & ~BVALID;
   wire ar_take = ARVALID & ARREADY;
   wire [9:0] count_inc = count + 10'h001;

   // a tick counts only while on and not paused
   wire tick = sel_tick & on & ~pause;

   // period match on the top three bits; code zero means overflow
   wire p_hit = (period == 3'h0) ? (count_inc == 10'h000) :
      ((count_inc[9:7] == period) &&
      (count_inc[6:0] == 7'h00));
   // match a never fires for an all-zero value, overflow is no match
   wire a_hit = (cmpa != 10'h000) && (count_inc == cmpa);

   // duty threshold, 11 bits so that 1024 fits
   wire [10:0] duty = swap ? {(period == 3'h0), period, 7'h00} :
      {1'b0, cmpa};
   wire pwm_on = ({1'b0, count} < duty);

   // internal prescaler; the high clock is taken as the system clock
   always @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
         prediv <= 6'h00;
      else
         prediv <= prediv + 6'h01;
   end

   // two-flop synchronisers, third flop for edge detection
   always @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         ext_s1 <= 1'b0;
         ext_s2 <= 1'b0;
         ext_s3 <= 1'b0;
         tb_s1 <= 1'b0;
         tb_s2 <= 1'b0;
         tb_s3 <= 1'b0;
         tp_s1 <= 1'b0;
         tp_s2 <= 1'b0;
         tp_s3 <= 1'b0;
      end
      else
      begin
         ext_s1 <= EXT_CLK_PIN;
         ext_s2 <= ext_s1;
         ext_s3 <= ext_s2;
         tb_s1 <= TIMEBASE_CLK;
         tb_s2 <= tb_s1;
         tb_s3 <= tb_s2;
         tp_s1 <= TP_IN;
         tp_s2 <= tp_s1;
         tp_s3 <= tp_s2;
      end
   end

   // count clock source select
   always @*
   begin
      case (cksel)
         `STM_CK_SYS_DIV4: sel_tick = (prediv[1:0] == 2'h3);
         `STM_CK_SYS: sel_tick = 1'b1;
         `STM_CK_HIGH_DIV16: sel_tick = (prediv[3:0] == 4'hF);
         `STM_CK_HIGH_DIV64: sel_tick = (prediv == 6'h3F);
         `STM_CK_TIMEBASE: sel_tick = tb_s2 & ~tb_s3;
         `STM_CK_PIN_RISE: sel_tick = ext_s2 & ~ext_s3;
         `STM_CK_PIN_FALL: sel_tick = ~ext_s2 & ext_s3;
         `STM_CK_UNDEFINED: sel_tick = 1'b0;
         default: sel_tick = 1'b0;
      endcase
   end

   // which match clears the counter depends on the mode
   always @*
   begin
      case (mode)
         `STM_MODE_PWM: clr_hit = swap ? a_hit : p_hit;
         `STM_MODE_CAPTURE: clr_hit = p_hit;
         `STM_MODE_COMPARE: clr_hit = clrsel ? a_hit : p_hit;
         `STM_MODE_TIMER: clr_hit = clrsel ? a_hit : p_hit;
         default: clr_hit = p_hit;
      endcase
   end

   // capture trigger edge of the synchronised pin
   always @*
   begin
      case (ofn)
         `STM_OFN_0: cap_edge = tp_s2 & ~tp_s3;
         `STM_OFN_1: cap_edge = ~tp_s2 & tp_s3;
         `STM_OFN_2: cap_edge = tp_s2 ^ tp_s3;
         default: cap_edge = 1'b0;
      endcase
   end

   // the 10-bit up counter; off and pause both simply hold it
   always @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         count <= 10'h000;
         on_prev <= 1'b0;
      end
      else
      begin
         on_prev <= on;
         if (on_rise)
            count <= 10'h000;
         else if (tick)
         begin
            if (clr_hit)
               count <= 10'h000;
            else
               count <= count_inc;
         end
      end
   end

   // compare-mode pin state and single pulse state
   always @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         out_state <= 1'b0;
         pulse_active <= 1'b0;
      end
      else
      begin
         if (on_rise)
            out_state <= init_lvl;
         else if (tick && a_hit && mode == `STM_MODE_COMPARE)
         begin
            // a requested level equal to the present one is no change
            case (ofn)
               `STM_OFN_1: out_state <= 1'b0;
               `STM_OFN_2: out_state <= 1'b1;
               `STM_OFN_3: out_state <= ~out_state;
               default: out_state <= out_state;
            endcase
         end
         if (on_rise)
            pulse_active <= 1'b1;
         else if (tick && a_hit)
            pulse_active <= 1'b0;
      end
   end

   // pin level and enable, registered before leaving the block
   always @*
   begin
      next_tp_oe = 1'b0;
      next_tp_out = 1'b0;
      case (mode)
         `STM_MODE_COMPARE:
         begin
            next_tp_oe = 1'b1;
            next_tp_out = out_state ^ pol;
         end
         `STM_MODE_PWM:
         begin
            next_tp_oe = 1'b1;
            case (ofn)
               `STM_OFN_0: next_tp_out = ~init_lvl;
               `STM_OFN_1: next_tp_out = init_lvl;
               `STM_OFN_2: next_tp_out = pwm_on ? init_lvl : ~init_lvl;
               default: next_tp_out = pulse_active ? init_lvl : ~init_lvl;
            endcase
            next_tp_out = next_tp_out ^ pol;
         end
         `STM_MODE_CAPTURE:
            next_tp_oe = 1'b0;
         `STM_MODE_TIMER:
            next_tp_oe = 1'b0;
         default:
            next_tp_oe = 1'b0;
      endcase
   end

   always @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         TP_OUT <= 1'b0;
         TP_OE <= 1'b0;
      end
      else
      begin
         TP_OUT <= next_tp_out;
         TP_OE <= next_tp_oe;
      end
   end

   // capture register, loaded on the chosen pin edge while on, paused or not
   always @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
         capture <= 10'h000;
      else if (mode == `STM_MODE_CAPTURE && on && cap_edge)
         capture <= count;
   end

   // sticky flags; a new event wins over a clear in the same cycle
   wire set_a = (mode == `STM_MODE_CAPTURE) ? (on & cap_edge) :
      (tick & a_hit);
   wire set_p = tick & p_hit & ~(clrsel &&
      (mode == `STM_MODE_COMPARE || mode == `STM_MODE_TIMER));
   wire clr_flags = do_write && w_lane0 &&
      (aw_addr == `STM_OFS_FLAGS);

   always @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         flag_a <= 1'b0;
         flag_p <= 1'b0;
      end
      else
      begin
         flag_a <= set_a | (flag_a &
            ~(clr_flags & w_data[`STM_FLAG_A_BIT]));
         flag_p <= set_p | (flag_p &
            ~(clr_flags & w_data[`STM_FLAG_P_BIT]));
      end
   end

   // write channel: address and data taken in either order
   always @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         AWREADY <= 1'b1;
         WREADY <= 1'b1;
         aw_got <= 1'b0;
         w_got <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_lane0 <= 1'b0;
         BVALID <= 1'b0;
         BRESP <= `STM_RESP_OKAY;
      end
      else
      begin
         if (AWVALID && AWREADY)
         begin
            aw_addr <= AWADDR;
            aw_got <= 1'b1;
            AWREADY <= 1'b0;
         end
         if (WVALID && WREADY)
         begin
            w_data <= WDATA;
            w_lane0 <= WSTRB[0];
            w_got <= 1'b1;
            WREADY <= 1'b0;
         end
         if (do_write)
         begin
            BVALID <= 1'b1;
            BRESP <= wr_ok ? `STM_RESP_OKAY : `STM_RESP_SLVERR;
         end
         if (BVALID && BREADY)
         begin
            BVALID <= 1'b0;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            AWREADY <= 1'b1;
            WREADY <= 1'b1;
         end
      end
   end

   // write address decode
   always @*
   begin
      case (aw_addr)
         `STM_OFS_CLOCK_PERIOD: wr_ok = 1'b1;
         `STM_OFS_MODE_OUTPUT: wr_ok = 1'b1;
         `STM_OFS_COUNT_LOW: wr_ok = 1'b1;
         `STM_OFS_COUNT_HIGH: wr_ok = 1'b1;
         `STM_OFS_CMPA_LOW: wr_ok = 1'b1;
         `STM_OFS_CMPA_HIGH: wr_ok = 1'b1;
         `STM_OFS_FLAGS: wr_ok = 1'b1;
         `STM_OFS_CAPTURE: wr_ok = 1'b1;
         default: wr_ok = 1'b0;
      endcase
   end

   // control and compare registers; only byte lane 0 carries data.
   // mode and output function are not interlocked with on/off: the
   // caller is trusted to switch the timer off first
   always @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         ctrl0 <= `STM_RST_CTRL;
         ctrl1 <= `STM_RST_CTRL;
         cmpa <= `STM_RST_CMPA;
      end
      else if (do_write && w_lane0)
      begin
         case (aw_addr)
            `STM_OFS_CLOCK_PERIOD: ctrl0 <= w_data[7:0];
            `STM_OFS_MODE_OUTPUT: ctrl1 <= w_data[7:0];
            `STM_OFS_CMPA_LOW: cmpa[7:0] <= w_data[7:0];
            `STM_OFS_CMPA_HIGH: cmpa[9:8] <= w_data[1:0];
            default: cmpa <= cmpa;
         endcase
      end
   end

   // read mux; counter and capture are read-only
   always @*
   begin
      rd_ok = 1'b1;
      case (ARADDR)
         `STM_OFS_CLOCK_PERIOD: rd_word = {24'h00_0000, ctrl0};
         `STM_OFS_MODE_OUTPUT: rd_word = {24'h00_0000, ctrl1};
         `STM_OFS_COUNT_LOW: rd_word = {24'h00_0000, count[7:0]};
         `STM_OFS_COUNT_HIGH: rd_word = {30'h0000_0000, count[9:8]};
         `STM_OFS_CMPA_LOW: rd_word = {24'h00_0000, cmpa[7:0]};
         `STM_OFS_CMPA_HIGH: rd_word = {30'h0000_0000, cmpa[9:8]};
         `STM_OFS_FLAGS: rd_word = {30'h0000_0000, flag_p, flag_a};
         `STM_OFS_CAPTURE: rd_word = {22'h00_0000, capture};
         default:
         begin
            rd_word = 32'h0000_0000;
            rd_ok = 1'b0;
         end
      endcase
   end

   // read channel: one read at a time, data one cycle after address
   always @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         ARREADY <= 1'b1;
         RVALID <= 1'b0;
         RDATA <= 32'h0000_0000;
         RRESP <= `STM_RESP_OKAY;
      end
      else
      begin
         if (ar_take)
         begin
            ARREADY <= 1'b0;
            RVALID <= 1'b1;
            RDATA <= rd_word;
            RRESP <= rd_ok ? `STM_RESP_OKAY : `STM_RESP_SLVERR;
         end
         else if (RVALID && RREADY)
         begin
            RVALID <= 1'b0;
            ARREADY <= 1'b1;
         end
      end
   end

endmodule // stm_ctrl

`default_nettype wire

/* File: logic/stm_map.vh */
// register map, field positions and reset values of the standard timer
`ifndef STM_MAP_VH
`define STM_MAP_VH

// byte addresses of the register words
`define STM_OFS_CLOCK_PERIOD 8'h00
`define STM_OFS_MODE_OUTPUT 8'h04
`define STM_OFS_COUNT_LOW 8'h08
`define STM_OFS_COUNT_HIGH 8'h0C
`define STM_OFS_CMPA_LOW 8'h10
`define STM_OFS_CMPA_HIGH 8'h14
`define STM_OFS_FLAGS 8'h18
`define STM_OFS_CAPTURE 8'h1C

// reset values
`define STM_RST_CTRL 8'h00
`define STM_RST_CMPA 10'h000

// timer_control_clock_period fields
`define STM_PAUSE_BIT 7
`define STM_CKSEL_HI 6
`define STM_CKSEL_LO 4
`define STM_ON_BIT 3
`define STM_PERIOD_HI 2
`define STM_PERIOD_LO 0

// timer_control_mode_output fields
`define STM_MODE_HI 7
`define STM_MODE_LO 6
`define STM_OFN_HI 5
`define STM_OFN_LO 4
`define STM_INIT_BIT 3
`define STM_POL_BIT 2
`define STM_SWAP_BIT 1
`define STM_CLRSEL_BIT 0

// flag register bits
`define STM_FLAG_A_BIT 0
`define STM_FLAG_P_BIT 1

// operating modes
`define STM_MODE_COMPARE 2'h0
`define STM_MODE_CAPTURE 2'h1
`define STM_MODE_PWM 2'h2
`define STM_MODE_TIMER 2'h3

// count clock sources
`define STM_CK_SYS_DIV4 3'h0
`define STM_CK_SYS 3'h1
`define STM_CK_HIGH_DIV16 3'h2
`define STM_CK_HIGH_DIV64 3'h3
`define STM_CK_TIMEBASE 3'h4
`define STM_CK_UNDEFINED 3'h5
`define STM_CK_PIN_RISE 3'h6
`define STM_CK_PIN_FALL 3'h7

// output function codes
`define STM_OFN_0 2'h0
`define STM_OFN_1 2'h1
`define STM_OFN_2 2'h2
`define STM_OFN_3 2'h3

// axi responses
`define STM_RESP_OKAY 2'h0
`define STM_RESP_SLVERR 2'h2

`endif

/* File: verif/stm_ctrl_props.sv */
// concurrent checks of the timer register bus and pin enable
`include "stm_map.vh"
`default_nettype none

module stm_ctrl_props
(
   input wire logic CLK, // system clock
   input wire logic ARST_N, // async reset, active low
   input wire logic TP_OE, // pin output enable
   input wire logic [7:0] AWADDR, // write address
   input wire logic AWVALID, // write address valid
   input wire logic AWREADY, // write address ready
   input wire logic [31:0] WDATA, // write data
   input wire logic [3:0] WSTRB, // write strobes
   input wire logic WVALID, // write data valid
   input wire logic WREADY, // write data ready
   input wire logic [1:0] BRESP, // write response
   input wire logic BVALID, // write response valid
   input wire logic BREADY, // write response ready
   input wire logic [7:0] ARADDR, // read address
   input wire logic ARVALID, // read address valid
   input wire logic ARREADY, // read address ready
   input wire logic [31:0] RDATA, // read data
   input wire logic [1:0] RRESP, // read response
   input wire logic RVALID, // read data valid
   input wire logic RREADY // read data ready
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!ARST_N);
   logic [7:0] waddr;
   logic [7:0] wbyte;
   logic wstb;
   logic [1:0] mode;

   // shadow of the mode field; lags the register so it never races it
   always @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         waddr <= 8'h00;
         wbyte <= 8'h00;
         wstb <= 1'b0;
         mode <= 2'h0;
      end
      else
      begin
         if (AWVALID && AWREADY) waddr <= AWADDR;
         if (WVALID && WREADY) wbyte <= WDATA[7:0];
         if (WVALID && WREADY) wstb <= WSTRB[0];
         if ($rose(BVALID) && waddr == `STM_OFS_MODE_OUTPUT && wstb)
            mode <= wbyte[7:6];
      end
   end

   sequence wr_taken;
      AWVALID && AWREADY && WVALID && WREADY;
   endsequence
   sequence rd_taken;
      ARVALID && ARREADY;
   endsequence

   chk_write_answer: assert property (wr_taken |=> !BVALID ##1 BVALID)
      else $error("write response not two edges after take");
   chk_read_answer: assert property (rd_taken |=> RVALID)
      else $error("read data not one edge after take");
   chk_bresp_hold: assert property
      (BVALID && !BREADY |=> BVALID && $stable(BRESP))
      else $error("write response dropped before taken");
   chk_rdata_hold: assert property
      (RVALID && !RREADY |=> RVALID && $stable(RDATA) && $stable(RRESP))
      else $error("read data dropped before taken");
   chk_write_busy: assert property (BVALID |-> !AWREADY && !WREADY)
      else $error("write accepted while response pending");
   chk_read_busy: assert property (RVALID |-> !ARREADY)
      else $error("read accepted while data pending");
   chk_ready_back: assert property (BVALID && BREADY |=> AWREADY && WREADY)
      else $error("write channels not ready after response");
   chk_unmapped_read: assert property ((rd_taken ##0 ARADDR > `STM_OFS_CAPTURE)
      |=> RRESP == `STM_RESP_SLVERR && RDATA == 32'h0000_0000)
      else $error("unmapped read not refused");
   chk_timer_undriven: assert property
      (mode == `STM_MODE_TIMER |-> !TP_OE)
      else $error("pin driven in plain timer mode");
   chk_capture_undriven: assert property
      (mode == `STM_MODE_CAPTURE |-> !TP_OE)
      else $error("pin driven in capture mode");
endmodule // stm_ctrl_props

bind stm_ctrl stm_ctrl_props u_props (.CLK(CLK), .ARST_N(ARST_N),
   .TP_OE(TP_OE), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
   .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
   .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
   .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
   .RVALID(RVALID), .RREADY(RREADY));
`default_nettype wire

/* File: verif/stm_pin_model.sv */
// pin-side model: external count clock, timebase clock and capture input
`default_nettype none

module stm_pin_model
(
   input wire logic clk, // system clock
   output logic ext_pin, // external count clock pin
   output logic tbase, // timebase clock
   output logic tp_in // timer pin seen as capture input
);
   timeunit 1ns;
   timeprecision 1ps;

   // all lines idle low; edges appear only when a test asks
   initial
   begin
      ext_pin = 1'b0;
      tbase = 1'b0;
      tp_in = 1'b0;
   end

   task automatic drive(input int sel, input logic v);
      if (sel == 1) ext_pin <= v;
      if (sel == 2) tbase <= v;
      if (sel == 3) tp_in <= v;
   endtask

   // n pulses on one line, w cycles each level; call just after an edge
   task automatic pulse(input int sel, input int n, input int w);
      repeat (n)
      begin
         drive(sel, 1'b1);
         repeat (w) @(posedge clk);
         drive(sel, 1'b0);
         repeat (w) @(posedge clk);
      end
   endtask
endmodule // stm_pin_model
`default_nettype wire

/* File: verif/tb_stm_ctrl.sv */
// self-checking bench of the timer control block over its register bus
`default_nettype none

module tb_stm_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   wire logic tp_out, tp_oe, awready, wready, bvalid, arready, rvalid;
   wire logic ext_pin, tbase, tp_in;
   wire logic [1:0] bresp, rresp;
   wire logic [31:0] rdata;
   int fails = 0;
   int comparisons = 0;
   logic [31:0] d;
   logic [1:0] r;
   logic [7:0] v;
   logic [9:0] cnt;
   int cyc[8] = '{400, 400, 800, 1280, 5, 100, 5, 5};
   int clo[8] = '{96, 400, 48, 19, 5, 0, 5, 5};
   int chi[8] = '{106, 412, 53, 22, 5, 0, 5, 5};
   logic [7:0] cm[10] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h18, 8'h24,
      8'h88, 8'h98, 8'hA8, 8'hB8};
   logic [1:0] ce[10] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2,
      2'h0, 2'h3, 2'h2, 2'h2};

   stm_ctrl uut (.CLK(clk), .ARST_N(arst_n), .EXT_CLK_PIN(ext_pin),
      .TIMEBASE_CLK(tbase), .TP_IN(tp_in), .TP_OUT(tp_out), .TP_OE(tp_oe),
      .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata),
      .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
      .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
      .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
      .RREADY(rready));
   stm_pin_model u_pins (.clk(clk), .ext_pin(ext_pin), .tbase(tbase),
      .tp_in(tp_in));

   // 50 MHz system clock
   always #10 clk = ~clk;

   task automatic check(input string name, input logic [31:0] seen,
      input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wrap_up;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // ready is looked at on the falling edge, so the take edge is race free
   task automatic wr(input logic [7:0] a, input logic [7:0] dv,
      output logic [1:0] rs);
      logic ta;
      logic tw;
      logic tb;
      @(posedge clk);
      awaddr <= a;
      wdata <= {24'h00_0000, dv};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      tb = 1'b0;
      while (!tb)
      begin
         @(negedge clk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bvalid;
         rs = bresp;
         @(posedge clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] dv,
      output logic [1:0] rs);
      logic ta;
      logic tr;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      tr = 1'b0;
      while (!tr)
      begin
         @(negedge clk);
         ta = arvalid && arready;
         tr = rvalid;
         dv = rdata;
         rs = rresp;
         @(posedge clk);
         if (ta) arvalid <= 1'b0;
      end
      rready <= 1'b0;
   endtask

   task automatic w(input logic [7:0] a, input logic [7:0] dv);
      logic [1:0] rs;
      wr(a, dv, rs);
   endtask

   task automatic rb(input logic [7:0] a, output logic [7:0] dv);
      logic [31:0] t;
      logic [1:0] rs;
      rd(a, t, rs);
      dv = t[7:0];
   endtask

   // off, rising on, count for a while, then pause and read the count
   task automatic run(input logic [7:0] c0, input int pin, input int n,
      output logic [9:0] c);
      logic [7:0] lo;
      logic [7:0] hi;
      w(8'h00, c0 & 8'h77);
      w(8'h00, c0 | 8'h08);
      if (pin != 0) u_pins.pulse(pin, n, 4);
      repeat (pin != 0 ? 8 : n) @(posedge clk);
      w(8'h00, c0 | 8'h88);
      rb(8'h08, lo);
      rb(8'h0C, hi);
      c = {hi[1:0], lo};
   endtask

   // watchdog far beyond the expected run of some 4600 cycles
   initial
   begin
      repeat (60000) @(posedge clk);
      fails++;
      wrap_up;
   end

   initial
   begin
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      // reset values and access kinds
      for (int a = 0; a <= 24; a += 4)
      begin
         rd(a[7:0], d, r);
         check("reset value", d, 32'h0000_0000);
      end
      w(8'h10, 8'hA5);
      rb(8'h10, v);
      check("compare low", v, 8'hA5);
      w(8'h14, 8'hFF);
      rb(8'h14, v);
      check("compare high", v, 8'h03);
      w(8'h0C, 8'h55);
      rb(8'h0C, v);
      check("counter read only", v, 8'h00);
      wr(8'h20, 8'h01, r);
      check("unmapped write", r, `STM_RESP_SLVERR);
      rd(8'h20, d, r);
      check("unmapped read", {d[29:0], r}, `STM_RESP_SLVERR);
      // every count clock source in plain timer mode
      w(8'h04, 8'hC0);
      repeat (2) @(negedge clk);
      check("timer pin enable", tp_oe, 1'b0);
      for (int i = 0; i < 8; i++)
      begin
         run({1'b0, i[2:0], 4'h0}, i == 4 ? 2 : (i > 5 ? 1 : 0), cyc[i], cnt);
         check("count floor", cnt >= clo[i], 1);
         check("count ceiling", cnt <= chi[i], 1);
         rb(8'h08, v);
         check("paused count held", v, cnt[7:0]);
      end
      // switch off first, else the on bit has no rising edge
      w(8'h00, 8'h90);
      w(8'h00, 8'h98);
      rb(8'h08, v);
      check("rising on clears", v, 8'h00);
      // period match and its sticky flag
      run(8'h11, 0, 300, cnt);
      check("period clear", cnt < 128, 1);
      rb(8'h18, v);
      check("period flag", v[1], 1'b1);
      w(8'h18, 8'h03);
      rb(8'h18, v);
      check("flags cleared", v, 8'h00);
      // pin level at switch-on and after match a, per function code
      w(8'h10, 8'h14);
      w(8'h14, 8'h00);
      for (int i = 0; i < 10; i++)
      begin
         w(8'h00, 8'h10);
         w(8'h04, cm[i]);
         w(8'h00, 8'h18);
         // state follows the on edge, the pin one register later
         repeat (2) @(negedge clk);
         check("pin at switch on", tp_out, ce[i][1]);
         repeat (60) @(negedge clk);
         check("pin after match", tp_out, ce[i][0]);
         check("pin enable", tp_oe, 1'b1);
      end
      // capture trigger codes on a full pin pulse
      w(8'h10, 8'h00);
      for (int i = 0; i < 4; i++)
      begin
         w(8'h00, 8'h10);
         w(8'h04, {2'h1, i[1:0], 4'h0});
         w(8'h00, 8'h18);
         w(8'h18, 8'h03);
         u_pins.pulse(3, 1, 2);
         repeat (8) @(posedge clk);
         rb(8'h18, v);
         check("capture flag", v[0], i != 3);
         check("capture pin enable", tp_oe, 1'b0);
      end
      wrap_up;
   end
endmodule // tb_stm_ctrl
`default_nettype wire
